//--- design/fewp_ctrl.v
`timescale 1ns/1ps
`include "fewp_map.vh"

// How it works
// - Opcodes 20h, 52h, D8h erase 4K/32K/64K blocks
// - Block erase needs write latch flag set
// - Three address bytes; extra bytes ignored
// - Erase starts at chip-select rise, self-timed
// - Low address bits ignored per block size
// - Short address or odd bit count aborts
// - Protected block: skip erase, go idle
// - Aborted block erase clears write latch flag
// - Busy while erasing; latch flag cleared before end
// - 60h and C7h both mean chip erase
// - Chip erase at chip-select rise, trailing ignored
// - Chip erase refused on odd count or protection
// - Rejected chip erase clears write latch flag
// - Write-type commands need latch flag set first
// - Opcode 06h sets latch flag at release
// - Truncated latch commands leave flag unchanged
// - Opcode 04h clears latch flag at release
// - Protection bits change only by status write or reset
// - Upper fractions protected when bottom select clear
// - Lower fractions protected when bottom select set
// - Level 000 none; 11x whole array, 101 whole array only when granularity bit clear
// - Granularity bit selects 4K-granular small regions
// - Complement bit inverts the protected region
// - Write-lock pin low freezes protection bits

module fewp_ctrl #(
	parameter BLOCK_ERASE_TIME_US = `FEWP_BLOCK_ERASE_TIME_US,
	parameter CHIP_ERASE_TIME_US = `FEWP_CHIP_ERASE_TIME_US,
	parameter TW = 24
) (
	input wire ref_clk,
	input wire resetn,
	input wire sck,
	input wire cs_n,
	input wire mosi,
	input wire wp_n,
	input wire sr_write_strobe,
	input wire [5:0] sr_write_data,
	output reg write_latch_flag_reg,
	output reg busy_reg,
	output reg erase_go_reg,
	output reg [1:0] erase_kind_reg,
	output reg [23:0] erase_addr_reg,
	output reg erase_done_reg,
	output reg cmd_abort_reg,
	output reg sr_write_ack_reg,
	output reg [5:0] prot_bits_reg
);

localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;
localparam [TW-1:0] BLK_US = BLOCK_ERASE_TIME_US[TW-1:0];
localparam [TW-1:0] CHIP_US = CHIP_ERASE_TIME_US[TW-1:0];

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg sck_s1_reg;
reg sck_s2_reg;
reg sck_s3_reg;
reg cs_s1_reg;
reg cs_s2_reg;
reg cs_s3_reg;
reg mosi_s1_reg;
reg mosi_s2_reg;
reg wp_s1_reg;
reg wp_s2_reg;

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		sck_s1_reg <= 1'b0;
		sck_s2_reg <= 1'b0;
		sck_s3_reg <= 1'b0;
		cs_s1_reg <= 1'b1;
		cs_s2_reg <= 1'b1;
		cs_s3_reg <= 1'b1;
		mosi_s1_reg <= 1'b0;
		mosi_s2_reg <= 1'b0;
		wp_s1_reg <= 1'b0;
		wp_s2_reg <= 1'b0;
	end else begin
		sck_s1_reg <= sck;
		sck_s2_reg <= sck_s1_reg;
		sck_s3_reg <= sck_s2_reg;
		cs_s1_reg <= cs_n;
		cs_s2_reg <= cs_s1_reg;
		cs_s3_reg <= cs_s2_reg;
		mosi_s1_reg <= mosi;
		mosi_s2_reg <= mosi_s1_reg;
		wp_s1_reg <= wp_n;
		wp_s2_reg <= wp_s1_reg;
	end
end

wire sck_rise = sck_s2_reg & ~sck_s3_reg;
wire cs_rise = cs_s2_reg & ~cs_s3_reg;
wire in_frame = ~cs_s2_reg;

// ----------------------------------------
// Frame shifter: opcode, then three address bytes
// ----------------------------------------
reg [2:0] bit_cnt_reg;
reg [2:0] byte_cnt_reg;
reg [6:0] shift_reg;
reg [7:0] opcode_reg;
reg [23:0] addr_reg;
wire [7:0] byte_in = {shift_reg, mosi_s2_reg};

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		bit_cnt_reg <= 3'h0;
		byte_cnt_reg <= 3'h0;
		shift_reg <= 7'h00;
		opcode_reg <= 8'h00;
		addr_reg <= 24'h000000;
	end else if (!in_frame) begin
		bit_cnt_reg <= 3'h0;
		byte_cnt_reg <= 3'h0;
	end else if (sck_rise) begin
		shift_reg <= byte_in[6:0];
		bit_cnt_reg <= bit_cnt_reg + 3'h1;
		if (bit_cnt_reg == 3'h7) begin
			if (byte_cnt_reg != `FEWP_BYTE_CNT_MAX) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
			if (byte_cnt_reg == 3'h0) begin
				opcode_reg <= byte_in;
			end else if (byte_cnt_reg <= `FEWP_ADDR_BYTES) begin
				addr_reg <= {addr_reg[15:0], byte_in};
			end
			// Later bytes are dropped
		end
	end
end

// ----------------------------------------
// Frame qualification at chip-select release
// ----------------------------------------
wire opcode_done = (byte_cnt_reg != 3'h0);
wire on_boundary = (bit_cnt_reg == 3'h0);
wire frame_ok = opcode_done && on_boundary;
wire addr_done = (byte_cnt_reg > `FEWP_ADDR_BYTES);

wire op_blk4 = (opcode_reg == `FEWP_OP_ERASE_4K);
wire op_blk32 = (opcode_reg == `FEWP_OP_ERASE_32K);
wire op_blk64 = (opcode_reg == `FEWP_OP_ERASE_64K);
wire op_block = op_blk4 | op_blk32 | op_blk64;
wire op_chip = (opcode_reg == `FEWP_OP_CHIP_A) | (opcode_reg == `FEWP_OP_CHIP_B);
wire op_set = (opcode_reg == `FEWP_OP_LATCH_SET);
wire op_clr = (opcode_reg == `FEWP_OP_LATCH_CLR);

// ----------------------------------------
// Block range in 4 Kbyte sectors
// ----------------------------------------
function [7:0] fewp_blk_span;
	input [1:0] kind;
	begin
		case (kind)
			`FEWP_KIND_32K: fewp_blk_span = `FEWP_SPAN_32K;
			`FEWP_KIND_64K: fewp_blk_span = `FEWP_SPAN_64K;
			default: fewp_blk_span = 8'h00;
		endcase
	end
endfunction

function [23:0] fewp_blk_mask;
	input [1:0] kind;
	begin
		case (kind)
			`FEWP_KIND_4K: fewp_blk_mask = `FEWP_MASK_4K;
			`FEWP_KIND_32K: fewp_blk_mask = `FEWP_MASK_32K;
			`FEWP_KIND_64K: fewp_blk_mask = `FEWP_MASK_64K;
			default: fewp_blk_mask = 24'h000000;
		endcase
	end
endfunction

wire [1:0] blk_kind = op_blk64 ? `FEWP_KIND_64K : (op_blk32 ? `FEWP_KIND_32K : `FEWP_KIND_4K);
wire [23:0] blk_addr = addr_reg & fewp_blk_mask(blk_kind);
wire [7:0] blk_lo = blk_addr[`FEWP_A_TOP:`FEWP_A_SECTOR_LSB];
wire [7:0] blk_hi = blk_lo | fewp_blk_span(blk_kind);

// ----------------------------------------
// Protection decode
// ----------------------------------------
wire [7:0] prot_lo;
wire [7:0] prot_hi;
wire prot_none;

fewp_prot_decode u_prot (
	.protect_complement(prot_bits_reg[`FEWP_NV_COMPL]),
	.sector_granularity(prot_bits_reg[`FEWP_NV_GRAN]),
	.top_bottom_select(prot_bits_reg[`FEWP_NV_TOPBOT]),
	.protect_level(prot_bits_reg[`FEWP_NV_LVL_HI:`FEWP_NV_LVL_LO]),
	.lo(prot_lo),
	.hi(prot_hi),
	.none(prot_none)
);

wire blk_protected = !prot_none && (blk_lo <= prot_hi) && (blk_hi >= prot_lo);
wire chip_protected = !prot_none;

// ----------------------------------------
// Erase timer
// ----------------------------------------
reg timer_start_reg;
reg [TW-1:0] timer_dur_reg;
wire timer_running;
wire timer_done;

fewp_erase_timer #(
	.DIV(`FEWP_CYC_PER_US),
	.TW(TW)
) u_timer (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.start(timer_start_reg),
	.dur_us(timer_dur_reg),
	.running_reg(timer_running),
	.done_reg(timer_done)
);

// ----------------------------------------
// Command decision and erase sequencing
// ----------------------------------------
reg state_reg;
reg state_next;
reg write_latch_flag_next;
reg go_next;
reg abort_next;
reg [1:0] kind_next;
reg [23:0] eaddr_next;
reg [TW-1:0] dur_next;

always @* begin
	state_next = state_reg;
	write_latch_flag_next = write_latch_flag_reg;
	go_next = 1'b0;
	abort_next = 1'b0;
	kind_next = erase_kind_reg;
	eaddr_next = erase_addr_reg;
	dur_next = timer_dur_reg;
	case (state_reg)
		ST_IDLE: begin
			if (sr_write_strobe && write_latch_flag_reg && wp_s2_reg) begin
				write_latch_flag_next = 1'b0;
			end
			if (cs_rise) begin
				if (op_set && frame_ok) begin
					write_latch_flag_next = 1'b1;
				end else if (op_clr && frame_ok) begin
					write_latch_flag_next = 1'b0;
				end else if (op_block && opcode_done && write_latch_flag_reg) begin
					if (!frame_ok || !addr_done || blk_protected) begin
						write_latch_flag_next = 1'b0;
						abort_next = 1'b1;
					end else begin
						go_next = 1'b1;
						kind_next = blk_kind;
						eaddr_next = blk_addr;
						dur_next = BLK_US;
						state_next = ST_BUSY;
					end
				end else if (op_chip && opcode_done && write_latch_flag_reg) begin
					if (!frame_ok || chip_protected) begin
						write_latch_flag_next = 1'b0;
						abort_next = 1'b1;
					end else begin
						go_next = 1'b1;
						kind_next = `FEWP_KIND_CHIP;
						eaddr_next = 24'h000000;
						dur_next = CHIP_US;
						state_next = ST_BUSY;
					end
				end
			end
		end
		ST_BUSY: begin
			// Latch flag drops once the erase is under way
			if (timer_running) begin
				write_latch_flag_next = 1'b0;
			end
			if (timer_done) begin
				state_next = ST_IDLE;
			end
		end
		default: begin
			state_next = ST_IDLE;
		end
	endcase
end

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		state_reg <= ST_IDLE;
		write_latch_flag_reg <= 1'b0;
		busy_reg <= 1'b0;
		erase_go_reg <= 1'b0;
		erase_kind_reg <= `FEWP_KIND_4K;
		erase_addr_reg <= 24'h000000;
		erase_done_reg <= 1'b0;
		cmd_abort_reg <= 1'b0;
		timer_start_reg <= 1'b0;
		timer_dur_reg <= {TW{1'b0}};
	end else begin
		state_reg <= state_next;
		write_latch_flag_reg <= write_latch_flag_next;
		busy_reg <= (state_next == ST_BUSY);
		erase_go_reg <= go_next;
		erase_kind_reg <= kind_next;
		erase_addr_reg <= eaddr_next;
		erase_done_reg <= timer_done;
		cmd_abort_reg <= abort_next;
		timer_start_reg <= go_next;
		timer_dur_reg <= dur_next;
	end
end

// ----------------------------------------
// Non-volatile protection bits
// ----------------------------------------
wire sr_accept = sr_write_strobe && (state_reg == ST_IDLE) && write_latch_flag_reg;
wire sr_unlocked = wp_s2_reg;

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		prot_bits_reg <= `FEWP_NV_RST;
		sr_write_ack_reg <= 1'b0;
	end else begin
		sr_write_ack_reg <= sr_accept && sr_unlocked;
		if (sr_accept && sr_unlocked) begin
			prot_bits_reg <= sr_write_data;
		end
	end
end

endmodule // fewp_ctrl

//--- design/fewp_erase_timer.v
`timescale 1ns/1ps
`include "fewp_map.vh"

module fewp_erase_timer #(
	parameter DIV = 200,
	parameter TW = 24
) (
	input wire ref_clk,
	input wire resetn,
	input wire start,
	input wire [TW-1:0] dur_us,
	output reg running_reg,
	output reg done_reg
);

reg [15:0] div_reg;
reg [TW-1:0] left_reg;
wire tick;

// ----------------------------------------
// Microsecond enable
// ----------------------------------------
assign tick = (div_reg == DIV[15:0] - 16'h0001);

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		div_reg <= 16'h0000;
	end else if (start || tick) begin
		div_reg <= 16'h0000;
	end else begin
		div_reg <= div_reg + 16'h0001;
	end
end

// ----------------------------------------
// Self-timed countdown
// ----------------------------------------
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		left_reg <= {TW{1'b0}};
		running_reg <= 1'b0;
		done_reg <= 1'b0;
	end else begin
		done_reg <= 1'b0;
		if (start) begin
			left_reg <= dur_us;
			running_reg <= 1'b1;
		end else if (running_reg && tick) begin
			if (left_reg <= {{(TW-1){1'b0}}, 1'b1}) begin
				left_reg <= {TW{1'b0}};
				running_reg <= 1'b0;
				done_reg <= 1'b1;
			end else begin
				left_reg <= left_reg - {{(TW-1){1'b0}}, 1'b1};
			end
		end
	end
end

endmodule // fewp_erase_timer

//--- design/fewp_map.vh
`ifndef FEWP_MAP_VH
`define FEWP_MAP_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FEWP_OP_ERASE_4K 8'h20
`define FEWP_OP_ERASE_32K 8'h52
`define FEWP_OP_ERASE_64K 8'hd8
`define FEWP_OP_CHIP_A 8'h60
`define FEWP_OP_CHIP_B 8'hc7
`define FEWP_OP_LATCH_SET 8'h06
`define FEWP_OP_LATCH_CLR 8'h04

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define FEWP_ADDR_BYTES 3'h3
`define FEWP_BYTE_CNT_MAX 3'h7

// ----------------------------------------
// Erase kinds
// ----------------------------------------
`define FEWP_KIND_4K 2'h0
`define FEWP_KIND_32K 2'h1
`define FEWP_KIND_64K 2'h2
`define FEWP_KIND_CHIP 2'h3

// ----------------------------------------
// Address fields, 1 Mbyte array of 256 sectors of 4 Kbyte
// ----------------------------------------
`define FEWP_SECTOR_W 8
`define FEWP_A_SECTOR_LSB 12
`define FEWP_A_TOP 19
`define FEWP_MASK_4K 24'hfff000
`define FEWP_MASK_32K 24'hff8000
`define FEWP_MASK_64K 24'hff0000
`define FEWP_SPAN_32K 8'h07
`define FEWP_SPAN_64K 8'h0f

// ----------------------------------------
// Protection field positions in the non-volatile word
// ----------------------------------------
`define FEWP_NV_COMPL 5
`define FEWP_NV_GRAN 4
`define FEWP_NV_TOPBOT 3
`define FEWP_NV_LVL_HI 2
`define FEWP_NV_LVL_LO 0
`define FEWP_NV_RST 6'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define FEWP_CLK_PERIOD_PS 5000
`define FEWP_US_PS 1000000
`define FEWP_CYC_PER_US (`FEWP_US_PS / `FEWP_CLK_PERIOD_PS)
`define FEWP_BLOCK_ERASE_TIME_US 1000
`define FEWP_CHIP_ERASE_TIME_US 4000

`endif

//--- design/fewp_prot_decode.v
`timescale 1ns/1ps
`include "fewp_map.vh"

module fewp_prot_decode (
	input wire protect_complement,
	input wire sector_granularity,
	input wire top_bottom_select,
	input wire [2:0] protect_level,
	output reg [7:0] lo,
	output reg [7:0] hi,
	output reg none
);

reg [8:0] n;
reg [8:0] n_eff;
reg [8:0] base;
reg [8:0] last;
reg top;

// ----------------------------------------
// Sector count of the plain region, then complement
// ----------------------------------------
always @* begin
	case (protect_level)
		3'h0: n = 9'h000;
		3'h1: n = sector_granularity ? 9'h001 : 9'h010;
		3'h2: n = sector_granularity ? 9'h002 : 9'h020;
		3'h3: n = sector_granularity ? 9'h004 : 9'h040;
		3'h4: n = sector_granularity ? 9'h008 : 9'h080;
		3'h5: n = sector_granularity ? 9'h008 : 9'h100;
		default: n = 9'h100;
	endcase
	n_eff = protect_complement ? (9'h100 - n) : n;
	top = protect_complement ? top_bottom_select : ~top_bottom_select;
	base = 9'h100 - n_eff;
	last = n_eff - 9'h001;
	none = (n_eff == 9'h000);
	lo = top ? base[7:0] : 8'h00;
	hi = top ? 8'hff : last[7:0];
end

endmodule // fewp_prot_decode

//--- dv/fewp_ctrl_sva.sv
`timescale 1ns/1ps
module fewp_ctrl_sva #(
	parameter BLOCK_ERASE_TIME_US = 2,
	parameter CHIP_ERASE_TIME_US = 3
) (
	input wire ref_clk,
	input wire resetn,
	input wire cs_n,
	input wire sr_write_strobe,
	input wire [5:0] sr_write_data,
	input wire write_latch_flag_reg,
	input wire busy_reg,
	input wire erase_go_reg,
	input wire [1:0] erase_kind_reg,
	input wire [23:0] erase_addr_reg,
	input wire erase_done_reg,
	input wire cmd_abort_reg,
	input wire sr_write_ack_reg,
	input wire [5:0] prot_bits_reg
);
	localparam int BLK_LO = BLOCK_ERASE_TIME_US * 200 - 4;
	localparam int BLK_HI = BLOCK_ERASE_TIME_US * 200 + 210;
	localparam int CHP_LO = CHIP_ERASE_TIME_US * 200 - 4;
	localparam int CHP_HI = CHIP_ERASE_TIME_US * 200 + 210;
	int busy_cnt;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			busy_cnt <= 0;
		else if (erase_go_reg)
			busy_cnt <= 1;
		else if (busy_reg)
			busy_cnt <= busy_cnt + 1;
	end

	a_go_needs_flag: assert property (
		erase_go_reg |-> $past(write_latch_flag_reg)) else $error("erase began without latch flag");
	a_go_start_cond: assert property (
		erase_go_reg |-> busy_reg && !$past(busy_reg) && cs_n && $past(cs_n, 3))
		else $error("erase began at wrong moment");
	a_flag_drops: assert property (
		erase_go_reg |-> ##[1:3] !write_latch_flag_reg) else $error("latch flag kept during erase");
	a_erase_span: assert property (
		erase_done_reg |-> busy_cnt >= ((erase_kind_reg == 2'h3) ? CHP_LO : BLK_LO)
		&& busy_cnt <= ((erase_kind_reg == 2'h3) ? CHP_HI : BLK_HI))
		else $error("erase time out of range");
	a_done_comes: assert property (
		erase_go_reg |-> ##[1:CHP_HI] erase_done_reg) else $error("erase never finished");
	a_done_ends_busy: assert property (
		erase_done_reg |-> !busy_reg && $past(busy_reg)) else $error("busy wrong at erase end");
	a_abort_clears: assert property (
		cmd_abort_reg |-> ##[0:1] !write_latch_flag_reg) else $error("abort kept latch flag");
	a_abort_no_go: assert property (
		cmd_abort_reg |-> !erase_go_reg && cs_n) else $error("abort with erase start");
	a_addr_align: assert property (
		erase_go_reg |-> erase_addr_reg[11:0] == 12'h000
		&& (erase_kind_reg == 2'h0 || erase_addr_reg[14:12] == 3'h0)
		&& (erase_kind_reg < 2'h2 || erase_addr_reg[15] == 1'b0)
		&& (erase_kind_reg != 2'h3 || erase_addr_reg == 24'h000000))
		else $error("erase base address not aligned");
	a_bits_hold: assert property (
		!sr_write_ack_reg |-> $stable(prot_bits_reg)) else $error("protection bits changed");
	a_ack_bits: assert property (
		sr_write_ack_reg |-> prot_bits_reg == $past(sr_write_data) && $past(sr_write_strobe)
		&& $past(write_latch_flag_reg) && !write_latch_flag_reg)
		else $error("status write result wrong");
endmodule // fewp_ctrl_sva

bind fewp_ctrl fewp_ctrl_sva #(
	.BLOCK_ERASE_TIME_US(BLOCK_ERASE_TIME_US),
	.CHIP_ERASE_TIME_US(CHIP_ERASE_TIME_US)
) u_sva (.ref_clk, .resetn, .cs_n, .sr_write_strobe, .sr_write_data, .write_latch_flag_reg,
	.busy_reg, .erase_go_reg, .erase_kind_reg, .erase_addr_reg, .erase_done_reg,
	.cmd_abort_reg, .sr_write_ack_reg, .prot_bits_reg);

//--- dv/fewp_ctrl_test.sv
`timescale 1ns/1ps
module fewp_ctrl_test;
	// f holds {set flag first, erase start, abort, flag after}; ka holds {kind, base}
	typedef struct {
		logic [5:0] prot;
		logic [3:0] f;
		logic [39:0] d;
		int n;
		logic [25:0] ka;
	} fewp_row_t;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wp_n = 1'b1;
	logic sr_write_strobe = 1'b0;
	logic [5:0] sr_write_data = 6'h00;
	logic [5:0] cur_prot = 6'h00;
	wire sck, cs_n, mosi, write_latch_flag_reg, busy_reg, erase_go_reg;
	wire erase_done_reg, cmd_abort_reg, sr_write_ack_reg;
	wire [1:0] erase_kind_reg;
	wire [23:0] erase_addr_reg;
	wire [5:0] prot_bits_reg;
	int fail_count = 0;
	int check_count = 0;
	int go_cnt = 0;
	int ab_cnt = 0;
	int ack_cnt = 0;
	int g;
	fewp_row_t rows[25] = '{
		'{6'h00, 4'hc, 40'h200abcde00, 32, 26'h00ab000}, '{6'h00, 4'hc, 40'h520abcde00, 32, 26'h10a8000},
		'{6'h00, 4'hc, 40'hd80abcde5a, 40, 26'h20a0000}, '{6'h00, 4'hc, 40'h6000000000, 8, 26'h3000000},
		'{6'h00, 4'hc, 40'hc7a5000000, 16, 26'h3000000}, '{6'h00, 4'ha, 40'h200abcde00, 24, 26'h0},
		'{6'h00, 4'ha, 40'h200abcde00, 33, 26'h0}, '{6'h00, 4'ha, 40'h6000000000, 12, 26'h0},
		'{6'h00, 4'h0, 40'h200abcde00, 32, 26'h0}, '{6'h00, 4'h0, 40'h0600000000, 7, 26'h0},
		'{6'h00, 4'h1, 40'h06ff000000, 16, 26'h0}, '{6'h00, 4'h0, 40'h0400000000, 8, 26'h0},
		'{6'h00, 4'h9, 40'h0400000000, 5, 26'h0}, '{6'h01, 4'ha, 40'hd80f000000, 32, 26'h0},
		'{6'h01, 4'hc, 40'hd80e000000, 32, 26'h20e0000}, '{6'h01, 4'ha, 40'hc700000000, 8, 26'h0},
		'{6'h0c, 4'ha, 40'h2007f00000, 32, 26'h0}, '{6'h0c, 4'hc, 40'h2008000000, 32, 26'h0080000},
		'{6'h05, 4'ha, 40'h2000000000, 32, 26'h0}, '{6'h06, 4'ha, 40'h520ff00000, 32, 26'h0},
		'{6'h21, 4'ha, 40'h200ef00000, 32, 26'h0}, '{6'h21, 4'hc, 40'h200ff00000, 32, 26'h00ff000},
		'{6'h20, 4'ha, 40'h200ff00000, 32, 26'h0}, '{6'h11, 4'ha, 40'h200ff00000, 32, 26'h0},
		'{6'h11, 4'hc, 40'h200fe00000, 32, 26'h00fe000}};

	fewp_host host (.sck, .cs_n, .mosi);
	fewp_ctrl #(.BLOCK_ERASE_TIME_US(2), .CHIP_ERASE_TIME_US(3)) dut (.ref_clk, .resetn, .sck,
		.cs_n, .mosi, .wp_n, .sr_write_strobe, .sr_write_data, .write_latch_flag_reg, .busy_reg,
		.erase_go_reg, .erase_kind_reg, .erase_addr_reg, .erase_done_reg, .cmd_abort_reg,
		.sr_write_ack_reg, .prot_bits_reg);

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		go_cnt <= go_cnt + int'(erase_go_reg);
		ab_cnt <= ab_cnt + int'(cmd_abort_reg);
		ack_cnt <= ack_cnt + int'(sr_write_ack_reg);
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 1000 && busy_reg !== 1'b0; i++)
			@(negedge ref_clk);
		chk(busy_reg, 1'b0);
	endtask
	task automatic prot_write(input logic [5:0] v);
		int k0;
		k0 = ack_cnt;
		host.frame(40'h0600000000, 8);
		@(negedge ref_clk);
		sr_write_strobe = 1'b1;
		sr_write_data = v;
		@(negedge ref_clk);
		sr_write_strobe = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(24'(ack_cnt - k0), 24'(wp_n));
		chk(prot_bits_reg, wp_n ? v : cur_prot);
		chk(write_latch_flag_reg, !wp_n);
		if (wp_n)
			cur_prot = v;
	endtask
	task automatic run_row(input fewp_row_t r);
		int a0;
		if (r.prot !== cur_prot)
			prot_write(r.prot);
		g = go_cnt;
		a0 = ab_cnt;
		if (r.f[3])
			host.frame(40'h0600000000, 8);
		host.frame(r.d, r.n);
		repeat (10) @(negedge ref_clk);
		chk(24'(go_cnt - g), 24'(r.f[2]));
		chk(24'(ab_cnt - a0), 24'(r.f[1]));
		if (r.f[2]) begin
			chk({erase_kind_reg, erase_addr_reg}, r.ka);
			wait_idle();
			chk(erase_done_reg, 1'b1);
		end
		chk(write_latch_flag_reg, r.f[0]);
	endtask

	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (5) @(negedge ref_clk);
		foreach (rows[i])
			run_row(rows[i]);
		// Frame sent while an erase runs must be ignored
		g = go_cnt;
		host.frame(40'h0600000000, 8);
		host.frame(40'h2000100000, 32);
		host.frame(40'h0600000000, 8);
		wait_idle();
		chk(write_latch_flag_reg, 1'b0);
		chk(24'(go_cnt - g), 24'h000001);
		// Write-lock pin freezes the protection bits
		wp_n = 1'b0;
		prot_write(6'h00);
		wp_n = 1'b1;
		// Reset in the middle of an erase
		host.frame(40'h0600000000, 8);
		host.frame(40'h2000100000, 32);
		chk(busy_reg, 1'b1);
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({busy_reg, write_latch_flag_reg, prot_bits_reg}, 8'h00);
		resetn = 1'b1;
		cur_prot = 6'h00;
		repeat (5) @(negedge ref_clk);
		// Status write with the latch flag clear is refused
		sr_write_data = 6'h3f;
		sr_write_strobe = 1'b1;
		@(negedge ref_clk);
		sr_write_strobe = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(prot_bits_reg, cur_prot);
		host.frame(40'h0600000000, 8);
		chk(write_latch_flag_reg, 1'b1);
		report_and_stop();
	end
endmodule // fewp_ctrl_test

//--- dv/fewp_host.sv
`timescale 1ns/1ps
module fewp_host (
	output logic sck,
	output logic cs_n,
	output logic mosi
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// One frame of n bits, MSB first; clock rests low between frames
	task automatic frame(input logic [39:0] d, input int n);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = d[39-i];
			#80 sck = 1'b1;
			#80 sck = 1'b0;
		end
		#80 cs_n = 1'b1;
		mosi = ~mosi;
		#400;
	endtask
endmodule // fewp_host
